// ### tc2_pkg.sv
// Package: register map, field layout and constants of the timer block
package tc2_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TC2_A_MASK  = 8'h70;
  localparam logic [7:0] TC2_A_CTLA  = 8'h80;
  localparam logic [7:0] TC2_A_CTLB  = 8'h84;
  localparam logic [7:0] TC2_A_CNT   = 8'h88;
  localparam logic [7:0] TC2_A_CMPA  = 8'h8C;
  localparam logic [7:0] TC2_A_FLAG  = 8'h90;
  localparam logic [7:0] TC2_A_BUSY  = 8'h94;
  localparam logic [7:0] TC2_A_GTC   = 8'h98;
  localparam logic [7:0] TC2_A_GIE   = 8'h9C;
  localparam logic [7:0] TC2_A_CMPB  = 8'hB4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TC2_B_OVF    = 0;   // Flag, mask bit: overflow
  localparam int TC2_B_BUSY_CB = 0;  // Busy: control B
  localparam int TC2_B_BUSY_CA = 1;  // Busy: control A
  localparam int TC2_B_BUSY_OB = 2;  // Busy: compare B
  localparam int TC2_B_ASYNC  = 3;   // Asynchronous mode select
  localparam int TC2_B_BUSY_OA = 4;  // Busy: compare A
  localparam int TC2_B_PSR    = 1;   // General control: prescaler reset
  localparam int TC2_B_TSM    = 7;   // General control: sync hold
  localparam logic [7:0] TC2_RST8  = 8'h00;
  localparam logic [2:0] TC2_MASK_W = 3'h7; // Writable mask bits
  localparam logic [7:0] TC2_CNT_MAX = 8'hFF;
  localparam logic [9:0] TC2_PRE_RST = 10'h000;
  localparam logic [9:0] TC2_PRE_ONE = 10'h001;
  localparam logic [7:0] TC2_CNT_ONE = 8'h01;
  localparam logic [2:0] TC2_CS_STOP = 3'h0;

  // Prescaler terminal masks per clock select: stop,1,8,32,64,128,256,1024
  localparam logic [9:0] TC2_DIV_MASK [8] = '{
    10'h000, 10'h000, 10'h007, 10'h01F,
    10'h03F, 10'h07F, 10'h0FF, 10'h3FF};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TC2_OM_OFF = 2'h0,
    TC2_OM_TGL = 2'h1,
    TC2_OM_CLR = 2'h2,
    TC2_OM_SET = 2'h3
  } tc2_omode_t;

  // Control A: output modes for both channels and clear-on-match-A
  typedef struct packed {
    tc2_omode_t mode_a;  // [7:6]
    tc2_omode_t mode_b;  // [5:4]
    logic [2:0] rsvd;    // [3:1]
    logic       ctc;     // [0]
  } tc2_ctla_t;

  // Control B: clock select
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] cs;
  } tc2_ctlb_t;

endpackage

// ### tc2_timer.sv
// Timer/counter 2 register control with APB slave and async update staging
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// R01 - Software reads and writes the 8-bit counter directly.
// R02 - A counter write blocks compare match on the next timer tick.
// R03 - Software avoids changing a running counter where missed matches matter.
// R04 - Compare A is checked against the counter; match sets flag or drives wave A.
// R05 - Compare B likewise for wave B; compare B resets to zero.
// R06 - Compare-B interrupt needs mask bit 2, global enable and its flag.
// R07 - Compare-A interrupt needs mask bit 1, global enable and its flag.
// R08 - Overflow interrupt needs mask bit 0, global enable and overflow flag.
// R09 - Async write of compare B sets busy bit 2 until transferred.
// R10 - Async write of control A sets busy bit 1 until transferred.
// R11 - Async write of control B sets busy bit 0 until transferred.
// R12 - Software does not write a register while its busy flag is set.
// R13 - Counter reads are live; compare and control reads return staging.
// R14 - Prescaler-reset bit resets the prescaler, then hardware clears it.
// R15 - In async mode the bit stays one until the reset has completed.
// R16 - While sync hold is set the prescaler-reset bit is not cleared.
// R17 - Overflow flag on wrap from max; compare flags on equality. Code: no overflow flag while clear-on-match-A is set.
// R18 - Upper five mask bits read zero and ignore writes.
module tc2_timer (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous timer clock, as one-cycle enable in the pclk domain
  input  wire logic        async_tick,
  // Waveform pins and interrupt
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              pready_q;
  logic [31:0]       prdata_q;
  logic              pslverr_q;
  logic [2:0]        mask_q;
  logic [2:0]        flag_q;
  logic              gie_q;
  logic              async_q;
  logic              tsm_q;
  logic              psr_q;
  logic [4:0]        busy_q;
  logic [7:0]        cnt_q;
  logic [9:0]        pre_q;
  logic              block_q;
  logic              irq_q;
  logic [7:0]        ctla_tmp_q;
  logic [7:0]        ctlb_tmp_q;
  tc2_pkg::tc2_ctla_t ctla_q;
  tc2_pkg::tc2_ctlb_t ctlb_q;
  logic [7:0]        cmp_tmp_q [2];
  logic [7:0]        cmp_q     [2];
  logic [1:0]        wave_q;
  logic [1:0]        match;
  logic [2:0]        flag_set;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: pready rises in the first access cycle's edge
  wire acc     = psel & penable;
  wire done    = acc & pready_q;
  wire wr      = done & pwrite;
  wire s_mask  = (paddr == tc2_pkg::TC2_A_MASK);
  wire s_ctla  = (paddr == tc2_pkg::TC2_A_CTLA);
  wire s_ctlb  = (paddr == tc2_pkg::TC2_A_CTLB);
  wire s_cnt   = (paddr == tc2_pkg::TC2_A_CNT);
  wire s_cmpa  = (paddr == tc2_pkg::TC2_A_CMPA);
  wire s_cmpb  = (paddr == tc2_pkg::TC2_A_CMPB);
  wire s_flag  = (paddr == tc2_pkg::TC2_A_FLAG);
  wire s_busy  = (paddr == tc2_pkg::TC2_A_BUSY);
  wire s_gtc   = (paddr == tc2_pkg::TC2_A_GTC);
  wire s_gie   = (paddr == tc2_pkg::TC2_A_GIE);
  wire mapped  = s_mask | s_ctla | s_ctlb | s_cnt | s_cmpa | s_cmpb |
                 s_flag | s_busy | s_gtc | s_gie;
  wire [7:0] wd = pwdata[7:0];
  wire w_cnt   = wr & s_cnt;
  wire w_ctla  = wr & s_ctla;
  wire w_ctlb  = wr & s_ctlb;
  wire [1:0] w_cmp = {wr & s_cmpb, wr & s_cmpa};

  // Read mux: counter is live, compare and control read staging copies
  wire [7:0] rd8 =
      s_mask ? {5'h00, mask_q} :                                   // [R18]
      s_ctla ? ctla_tmp_q :                                        // [R13]
      s_ctlb ? ctlb_tmp_q :                                        // [R13]
      s_cnt  ? cnt_q :                                             // [R01] [R13]
      s_cmpa ? cmp_tmp_q[0] :                                      // [R13]
      s_cmpb ? cmp_tmp_q[1] :                                      // [R13]
      s_flag ? {5'h00, flag_q} :
      s_busy ? {3'h0, busy_q[tc2_pkg::TC2_B_BUSY_OA], async_q,
                busy_q[2:0]} :
      s_gtc  ? {tsm_q, 5'h00, psr_q, 1'b0} :
      s_gie  ? {7'h00, gie_q} : tc2_pkg::TC2_RST8;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc & ~pready_q & ~pwrite) ? {24'h00_0000, rd8} : prdata_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Timer clock source and prescaler
  // ----------------------------------------------------------------
  // In async mode the prescaler advances only on the external tick
  wire src_en  = async_q ? async_tick : 1'b1;
  wire [9:0] div_mask = tc2_pkg::TC2_DIV_MASK[ctlb_q.cs];
  wire run     = (ctlb_q.cs != tc2_pkg::TC2_CS_STOP);
  wire tick    = run & src_en & ~psr_q & ((pre_q & div_mask) == div_mask);
  // Reset completes on a source edge; sync hold keeps the bit set
  wire psr_clr = psr_q & ~tsm_q & src_en;                         // [R15] [R16]
  wire psr_set = wr & s_gtc & wd[tc2_pkg::TC2_B_PSR];

  // Prescaler, held in reset while the reset bit is one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= tc2_pkg::TC2_PRE_RST;
    end else if (psr_q) begin
      pre_q <= tc2_pkg::TC2_PRE_RST;                              // [R14]
    end else if (src_en & run) begin
      pre_q <= pre_q + tc2_pkg::TC2_PRE_ONE;
    end
  end

  // General control: set wins over the hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psr_q <= 1'b0;
      tsm_q <= 1'b0;
    end else begin
      psr_q <= psr_set | (psr_q & ~psr_clr);                      // [R14]
      tsm_q <= (wr & s_gtc) ? wd[tc2_pkg::TC2_B_TSM] : tsm_q;
    end
  end

  // ----------------------------------------------------------------
  // Control staging and busy flags
  // ----------------------------------------------------------------
  // Sync mode copies at once; async copies on the next source edge
  wire xfer = async_q & async_tick;
  wire [4:0] busy_set = async_q ?
      {w_cmp[0], 1'b0, w_cmp[1], w_ctla, w_ctlb} : 5'h00;          // [R09] [R10] [R11]
  // Synchronous staging copies land immediately
  wire now  = ~async_q;

  // Busy flags: a write in the transfer cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 5'h00;
    end else begin
      busy_q <= busy_set | (xfer ? 5'h00 : busy_q);               // [R09] [R10] [R11]
    end
  end

  // Control A and B staging and working copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctla_tmp_q <= tc2_pkg::TC2_RST8;
      ctlb_tmp_q <= tc2_pkg::TC2_RST8;
      ctla_q     <= tc2_pkg::TC2_RST8;
      ctlb_q     <= tc2_pkg::TC2_RST8;
    end else begin
      ctla_tmp_q <= w_ctla ? wd : ctla_tmp_q;
      ctlb_tmp_q <= w_ctlb ? wd : ctlb_tmp_q;
      if (now & w_ctla) begin
        ctla_q <= wd;
      end else if (xfer & busy_q[tc2_pkg::TC2_B_BUSY_CA]) begin
        ctla_q <= ctla_tmp_q;                                     // [R10]
      end
      if (now & w_ctlb) begin
        ctlb_q <= wd;
      end else if (xfer & busy_q[tc2_pkg::TC2_B_BUSY_CB]) begin
        ctlb_q <= ctlb_tmp_q;                                     // [R11]
      end
    end
  end

  // Mode, mask and global enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_q <= 1'b0;
      mask_q  <= 3'h0;
      gie_q   <= 1'b0;
    end else begin
      async_q <= (wr & s_busy) ? wd[tc2_pkg::TC2_B_ASYNC] : async_q;
      mask_q  <= (wr & s_mask) ? (wd[2:0] & tc2_pkg::TC2_MASK_W) : mask_q; // [R18]
      gie_q   <= (wr & s_gie) ? wd[0] : gie_q;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  wire wrap = tick & ~ctla_q.ctc & (cnt_q == tc2_pkg::TC2_CNT_MAX);
  wire ctc_clr = tick & ctla_q.ctc & match[0];

  // Counter: software write overrides the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= tc2_pkg::TC2_RST8;
    end else if (w_cnt) begin
      cnt_q <= wd;                                                // [R01]
    end else if (ctc_clr) begin
      cnt_q <= tc2_pkg::TC2_RST8;
    end else if (tick) begin
      cnt_q <= cnt_q + tc2_pkg::TC2_CNT_ONE;
    end
  end

  // Compare blocking after a counter write, released by a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_q <= 1'b0;
    end else begin
      block_q <= w_cnt | (block_q & ~tick);                       // [R02]
    end
  end

  // ----------------------------------------------------------------
  // Compare channels: 0 is A, 1 is B
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cmp
      wire busy_ch = busy_q[(ch == 0) ? tc2_pkg::TC2_B_BUSY_OA
                                      : tc2_pkg::TC2_B_BUSY_OB];
      wire tc2_pkg::tc2_omode_t om = (ch == 0) ? ctla_q.mode_a : ctla_q.mode_b;
      // Match only on a tick that is not blocked by a counter write
      assign match[ch] = tick & ~block_q & (cnt_q == cmp_q[ch]);  // [R02] [R04] [R05]
      assign flag_set[ch + 1] = match[ch];                        // [R17]

      // Staging and working compare value
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_tmp_q[ch] <= tc2_pkg::TC2_RST8;                     // [R05]
          cmp_q[ch]     <= tc2_pkg::TC2_RST8;
        end else begin
          cmp_tmp_q[ch] <= w_cmp[ch] ? wd : cmp_tmp_q[ch];
          if (now & w_cmp[ch]) begin
            cmp_q[ch] <= wd;
          end else if (xfer & busy_ch) begin
            cmp_q[ch] <= cmp_tmp_q[ch];                           // [R09]
          end
        end
      end

      // Waveform pin driven by the output mode on each match
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wave_q[ch] <= 1'b0;
        end else if (match[ch]) begin
          unique case (om)
            tc2_pkg::TC2_OM_OFF: wave_q[ch] <= wave_q[ch];
            tc2_pkg::TC2_OM_TGL: wave_q[ch] <= ~wave_q[ch];        // [R04] [R05]
            tc2_pkg::TC2_OM_CLR: wave_q[ch] <= 1'b0;
            tc2_pkg::TC2_OM_SET: wave_q[ch] <= 1'b1;
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  assign flag_set[tc2_pkg::TC2_B_OVF] = wrap;                     // [R17]
  wire [2:0] flag_clr = (wr & s_flag) ? wd[2:0] : 3'h0;

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 3'h0;
    end else begin
      flag_q <= flag_set | (flag_q & ~flag_clr);                  // [R17]
    end
  end

  // Interrupt level: any enabled flag while the global enable is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= gie_q & |(flag_q & mask_q);                        // [R06] [R07] [R08]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign wave_out_a = wave_q[0];
  assign wave_out_b = wave_q[1];
  assign irq        = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_cnt_write: assert property (w_cnt |=> cnt_q == $past(wd)) // [R01]
    else $error("counter write not applied");
  chk_block_match: assert property (block_q |-> match == 2'b00) // [R02]
    else $error("match while blocked");
  chk_flag_a: assert property (match[0] |=> flag_q[1]) // [R04]
    else $error("compare A flag not set");
  chk_flag_b: assert property (match[1] |=> flag_q[2]) // [R05]
    else $error("compare B flag not set");
  chk_irq_b: assert property (gie_q && mask_q[2] && flag_q[2] |=> irq_q) // [R06]
    else $error("compare B interrupt missing");
  chk_irq_a: assert property (gie_q && mask_q[1] && flag_q[1] |=> irq_q) // [R07]
    else $error("compare A interrupt missing");
  chk_irq_ovf: assert property (gie_q && mask_q[0] && flag_q[0] |=> irq_q) // [R08]
    else $error("overflow interrupt missing");
  chk_irq_gie: assert property (!gie_q |=> !irq_q) // [R08]
    else $error("interrupt without global enable");
  chk_busy_b: assert property (async_q && w_cmp[1] |=> busy_q[2]) // [R09]
    else $error("compare B busy not set");
  chk_busy_ca: assert property (busy_q[1] && xfer && !w_ctla |=> !busy_q[1] // [R10]
                                && ctla_q == $past(ctla_tmp_q))
    else $error("control A transfer wrong");
  chk_busy_cb: assert property (async_q && w_ctlb |=> busy_q[0]) // [R11]
    else $error("control B busy not set");
  chk_read_stage: assert property (acc && !pready_q && !pwrite && s_cmpb // [R13]
                                   |=> prdata_q[7:0] == cmp_tmp_q[1])
    else $error("compare B read not staging");
  chk_psr_sync: assert property (psr_q && !async_q && !tsm_q && !psr_set // [R14]
                                 |=> !psr_q ##0 pre_q == tc2_pkg::TC2_PRE_RST)
    else $error("prescaler reset bit not cleared");
  chk_psr_async: assert property (psr_q && async_q && !async_tick |=> psr_q) // [R15]
    else $error("prescaler reset bit cleared early");
  chk_psr_hold: assert property (psr_q && tsm_q |=> psr_q) // [R16]
    else $error("prescaler reset bit cleared under hold");
  // A counter write in the wrap cycle wins over the wrap, so it is left out
  chk_ovf_wrap: assert property (wrap && !w_cnt |=> flag_q[0] && cnt_q == tc2_pkg::TC2_RST8) // [R17]
    else $error("overflow not flagged");
  chk_mask_upper: assert property (acc && !pready_q && !pwrite && s_mask // [R18]
                                   |=> prdata_q[7:3] == 5'h00)
    else $error("mask upper bits not zero");

  // Staging transfers, blocking, set-wins flags and the bus answer shape
  chk_busy_ob_xfer: assert property (busy_q[2] && xfer && !w_cmp[1] |=> !busy_q[2] // [R09]
                                     && cmp_q[1] == $past(cmp_tmp_q[1]))
    else $error("compare B transfer wrong");
  chk_busy_cb_xfer: assert property (busy_q[0] && xfer && !w_ctlb |=> !busy_q[0] // [R11]
                                     && ctlb_q == $past(ctlb_tmp_q))
    else $error("control B transfer wrong");
  chk_block_set: assert property (w_cnt |=> block_q) // [R02]
    else $error("counter write did not arm blocking");
  chk_flag_set_wins: assert property (flag_set[0] |=> flag_q[0]) // [R17]
    else $error("overflow lost against clear");
  // One wait state means pready never stands two cycles in a row
  chk_pready_pulse: assert property (pready_q |=> !pready_q)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");

endmodule

// ### tb_async_timer2_register_control.sv
// Self-checking testbench for the timer register block over APB
`timescale 1ns/1ps
module tb_async_timer2_register_control;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic        async_tick = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wave_out_a;
  logic        wave_out_b;
  logic        irq;
  int          err_count    = 0;
  int          total_checks = 0;

  // 100 MHz processor clock
  always #5 pclk = ~pclk;

  tc2_timer i_tc2_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .async_tick (async_tick),
    .wave_out_a (wave_out_a),
    .wave_out_b (wave_out_b),
    .irq        (irq)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin
      $display("[FAIL] pready expected 1 seen timeout");
      err_count++;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, {24'h000000, d}, rd, er);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string name);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk(name, {24'h000000, e}, rd);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One edge of the asynchronous timer clock
  task automatic tick();
    @(posedge pclk);
    async_tick <= 1'b1;
    @(posedge pclk);
    async_tick <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] rd;
    logic        er;
    rdchk(tc2_pkg::TC2_A_MASK, 8'h00, "mask reset");
    rdchk(tc2_pkg::TC2_A_CMPB, 8'h00, "cmpb reset");
    rdchk(tc2_pkg::TC2_A_FLAG, 8'h00, "flags reset");
    rdchk(tc2_pkg::TC2_A_BUSY, 8'h00, "busy reset");
    wr(tc2_pkg::TC2_A_MASK, 8'hFF);
    rdchk(tc2_pkg::TC2_A_MASK, 8'h07, "mask upper bits");
    // Unmapped place: refused, nothing read back
    apb(1'b1, 8'hC0, 32'h0000_00FF, rd, er);
    chk("unmapped write err", 32'h1, {31'h0, er});
    apb(1'b0, 8'hC0, 32'h0000_0000, rd, er);
    chk("unmapped read err", 32'h1, {31'h0, er});
    chk("unmapped read data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_count();
    wr(tc2_pkg::TC2_A_CNT, 8'h55);
    rdchk(tc2_pkg::TC2_A_CNT, 8'h55, "counter rw");
    wr(tc2_pkg::TC2_A_CNT, 8'hAA);
    rdchk(tc2_pkg::TC2_A_CNT, 8'hAA, "counter live");
    $display("test counter done");
  endtask

  task automatic t_match_irq();
    wr(tc2_pkg::TC2_A_MASK, 8'h00);
    wr(tc2_pkg::TC2_A_CMPA, 8'h10);
    wr(tc2_pkg::TC2_A_CMPB, 8'h20);
    wr(tc2_pkg::TC2_A_CNT, 8'h00);
    wr(tc2_pkg::TC2_A_CTLA, 8'hF0); // Both outputs set on match
    wr(tc2_pkg::TC2_A_CTLB, 8'h01); // Run at full rate
    cyc(300);                      // Longer than one wrap of the counter
    wr(tc2_pkg::TC2_A_CTLB, 8'h00);
    rdchk(tc2_pkg::TC2_A_FLAG, 8'h07, "all flags");
    chk("wave a", 32'h1, {31'h0, wave_out_a});
    chk("wave b", 32'h1, {31'h0, wave_out_b});
    wr(tc2_pkg::TC2_A_GIE, 8'h01);
    cyc(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    for (int i = 0; i < 3; i++) begin
      wr(tc2_pkg::TC2_A_MASK, 8'h01 << i);
      cyc(2);
      chk("irq per enable", 32'h1, {31'h0, irq});
    end
    wr(tc2_pkg::TC2_A_GIE, 8'h00);
    cyc(2);
    chk("irq no global", 32'h0, {31'h0, irq});
    wr(tc2_pkg::TC2_A_GIE, 8'h01);
    // Clearing only the overflow flag leaves its enable without cause
    wr(tc2_pkg::TC2_A_MASK, 8'h01);
    wr(tc2_pkg::TC2_A_FLAG, 8'h01);
    rdchk(tc2_pkg::TC2_A_FLAG, 8'h06, "ovf cleared");
    cyc(2);
    chk("irq ovf gone", 32'h0, {31'h0, irq});
    wr(tc2_pkg::TC2_A_FLAG, 8'h06);
    rdchk(tc2_pkg::TC2_A_FLAG, 8'h00, "flags cleared");
    $display("test match and interrupt done");
  endtask

  task automatic t_block();
    wr(tc2_pkg::TC2_A_CMPA, 8'h30);
    wr(tc2_pkg::TC2_A_CMPB, 8'hF0);
    wr(tc2_pkg::TC2_A_CNT, 8'h30);  // Equal to compare A while stopped
    wr(tc2_pkg::TC2_A_CTLB, 8'h01);
    wr(tc2_pkg::TC2_A_CTLB, 8'h00);
    rdchk(tc2_pkg::TC2_A_FLAG, 8'h00, "match blocked");
    // Control case: a few ticks ahead of the compare value does match
    wr(tc2_pkg::TC2_A_CNT, 8'h2E);
    wr(tc2_pkg::TC2_A_CTLB, 8'h01);
    wr(tc2_pkg::TC2_A_CTLB, 8'h00);
    rdchk(tc2_pkg::TC2_A_FLAG, 8'h02, "match a only");
    wr(tc2_pkg::TC2_A_FLAG, 8'h07);
    $display("test match blocking done");
  endtask

  task automatic t_busy();
    logic [7:0] adr [3];
    logic [7:0] val [3];
    adr = '{tc2_pkg::TC2_A_CMPB, tc2_pkg::TC2_A_CTLA, tc2_pkg::TC2_A_CTLB};
    val = '{8'h44, 8'h00, 8'h00};
    wr(tc2_pkg::TC2_A_BUSY, 8'h08); // Enter asynchronous mode
    rdchk(tc2_pkg::TC2_A_BUSY, 8'h08, "async mode");
    // Each write waits for the previous busy bit to drop
    for (int i = 0; i < 3; i++) begin
      wr(adr[i], val[i]);
      rdchk(tc2_pkg::TC2_A_BUSY, 8'h08 | (8'h04 >> i), "busy set");
      rdchk(adr[i], val[i], "staging read");
      tick();
      cyc(2);
      rdchk(tc2_pkg::TC2_A_BUSY, 8'h08, "busy clear");
    end
    rdchk(tc2_pkg::TC2_A_CMPB, 8'h44, "cmpb kept");
    $display("test update busy done");
  endtask

  task automatic t_presc();
    wr(tc2_pkg::TC2_A_GTC, 8'h02);
    rdchk(tc2_pkg::TC2_A_GTC, 8'h02, "psr held async");
    tick();
    cyc(2);
    rdchk(tc2_pkg::TC2_A_GTC, 8'h00, "psr done async");
    wr(tc2_pkg::TC2_A_BUSY, 8'h00); // Back to synchronous mode
    wr(tc2_pkg::TC2_A_GTC, 8'h02);
    rdchk(tc2_pkg::TC2_A_GTC, 8'h00, "psr self clear");
    wr(tc2_pkg::TC2_A_GTC, 8'h82);
    rdchk(tc2_pkg::TC2_A_GTC, 8'h82, "psr sync hold");
    wr(tc2_pkg::TC2_A_GTC, 8'h00);
    rdchk(tc2_pkg::TC2_A_GTC, 8'h00, "psr released");
    $display("test prescaler reset done");
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run is near 600 cycles; the limit of 20000 cycles leaves wide margin
  initial begin
    #200000;
    $display("[FAIL] watchdog expected done seen hang");
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_match_irq();
    t_block();
    t_busy();
    t_presc();
    wrap_up();
  end

endmodule
